/* File: pkg/seidp_pkg.sv */
package seidp_pkg;

  // ==========================================================================
  // Page geometry and error correction
  localparam int ID_BYTES = 32;
  localparam int GROUP_BYTES = 4;
  localparam int GROUPS = ID_BYTES / GROUP_BYTES;
  localparam int DATA_W = 32;
  localparam int ECC_W = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================================
  // Instruction codes and field positions
  localparam logic [7:0] OP_X_MASK = 8'hF7;
  localparam logic [7:0] OP_ID_READ = 8'h83;
  localparam logic [7:0] OP_ID_WRITE = 8'h82;
  localparam logic [7:0] OP_SET_LATCH_DEF = 8'h06;
  localparam int ADDR_SEL_BIT = 7;
  localparam int LOCK_DATA_BIT = 1;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WR_TIME_MS = 4;
  localparam int WR_CYCLES = WR_TIME_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Events handed from the serial link to the core at deselect, and the core states
  typedef enum logic [1:0] {EV_NONE, EV_SET_LATCH, EV_LOCK} seidp_evt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LOCK, ST_WRITE} seidp_state_t;

  // Hamming check bits over one group; data bits fill the non power of two slots.
  function automatic logic [ECC_W-1:0] seidp_ecc_gen(input logic [DATA_W-1:0] d);
    logic [ECC_W-1:0] c;
    int di;
    c = '0;
    di = 0;
    for (int p = 1; p <= DATA_W + ECC_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < ECC_W; i++) begin
          if (p[i]) begin
            c[i] = c[i] ^ d[di];
          end
        end
        di++;
      end
    end
    return c;
  endfunction

  // Flips the single data bit that the syndrome points at, if any.
  function automatic logic [DATA_W-1:0] seidp_ecc_fix(input logic [DATA_W-1:0] d,
                                                     input logic [ECC_W-1:0] chk);
    logic [ECC_W-1:0] syn;
    logic [DATA_W-1:0] r;
    int di;
    syn = seidp_ecc_gen(d) ^ chk;
    r = d;
    di = 0;
    for (int p = 1; p <= DATA_W + ECC_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn == p[ECC_W-1:0]) begin
          r[di] = ~d[di];
        end
        di++;
      end
    end
    return r;
  endfunction

endpackage

/* File: hw/seidp_idmem.sv */
`timescale 1ns/1ps
module seidp_idmem
  import seidp_pkg::*;
#(
  parameter int NGROUPS = GROUPS
) (
  // Write side, core clock
  input wire logic wclk,
  input wire logic we,
  input wire logic [$clog2(NGROUPS)+1:0] waddr,
  input wire logic [7:0] wdata,
  // Read side, link clock
  input wire logic rclk,
  input wire logic [$clog2(NGROUPS)-1:0] rgrp,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W+ECC_W-1:0] mem [NGROUPS];
  logic [DATA_W+ECC_W-1:0] q_ff;
  logic [DATA_W-1:0] old_word;
  logic [DATA_W-1:0] new_word;

  // ==========================================================================
  // Delivery content: every byte erased, with matching check bits.
  initial begin
    for (int g = 0; g < NGROUPS; g++) begin
      mem[g] = {seidp_ecc_gen({GROUP_BYTES{ERASED_BYTE}}), {GROUP_BYTES{ERASED_BYTE}}};
    end
  end

  // ==========================================================================
  // A byte write merges into the corrected group and stores all four bytes.
  always_comb begin
    old_word = seidp_ecc_fix(mem[waddr[$clog2(NGROUPS)+1:2]][DATA_W-1:0],
                             mem[waddr[$clog2(NGROUPS)+1:2]][DATA_W+ECC_W-1:DATA_W]);
    new_word = old_word;
    new_word[{waddr[1:0], 3'b000} +: 8] = wdata;
  end

  // A plain clocked block, since the delivery image above also writes the array.
  always @(posedge wclk) begin
    if (we) begin
      mem[waddr[$clog2(NGROUPS)+1:2]] <= {seidp_ecc_gen(new_word), new_word};
    end
  end

  // Dual-clock array: a read of the group being written in the same
  // instant may return either word; the core does not hold off a write while a frame read is in progress.
  always_ff @(posedge rclk) begin
    q_ff <= mem[rgrp];
  end

  assign rdata = seidp_ecc_fix(q_ff[DATA_W-1:0], q_ff[DATA_W+ECC_W-1:DATA_W]);

endmodule // seidp_idmem

/* File: hw/seidp_top.sv */
`timescale 1ns/1ps
module seidp_top
  import seidp_pkg::*;
#(
  parameter int WR_CYCLES_P = WR_CYCLES,
  parameter logic [7:0] SET_LATCH_CODE = OP_SET_LATCH_DEF
) (
  // Core clock and power-on reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // Status register protect selection
  input wire logic protect_sel_high,
  input wire logic protect_sel_low,
  // Page content load port
  input wire logic wr_req,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic wr_ack,
  // Status
  output logic write_latch_bit,
  output logic busy,
  output logic page_locked
);

  localparam int TW = $clog2(WR_CYCLES_P + 1);
  localparam int GW = $clog2(GROUPS);

  // ==========================================================================
  // Elaboration checks
  if (WR_CYCLES_P < 1) begin : g_chk_cycles
    $error("seidp_top: write cycle count must be at least one");
  end
  if (ID_BYTES != 32 || GROUP_BYTES != 4) begin : g_chk_geom
    $error("seidp_top: address decode assumes a 32 byte page of 4 byte groups");
  end

  // ==========================================================================
  // State types, one per clock domain and reset
  typedef struct packed {
    logic [2:0] bitpos;
    logic [1:0] byte_idx;
    logic [7:0] sr;
    logic [7:0] cmd;
    logic a7;
    logic rd_id;
    logic rd_ls;
    logic [5:0] addr;
    logic load;
  } seidp_link_t;

  typedef struct packed {
    seidp_evt_t evt;
    logic busy_s1;
    logic busy_s2;
    logic lock_s1;
    logic lock_s2;
  } seidp_keep_t;

  typedef struct packed {
    logic [7:0] so_sh;
  } seidp_out_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    seidp_evt_t evt_s1;
    seidp_evt_t evt_s2;
    logic wr_latch;
    seidp_state_t state;
    logic [TW-1:0] timer;
    logic locked;
    logic mem_we;
    logic [4:0] mem_addr;
    logic [7:0] mem_data;
    logic ack;
  } seidp_core_t;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  seidp_link_t link_ff, nxt_link;
  seidp_keep_t keep_ff, nxt_keep;
  seidp_out_t out_ff, nxt_out;
  seidp_core_t core_ff, nxt_core;
  logic [7:0] byte_in;
  logic [5:0] addr_inc;
  logic is_read_op;
  logic is_lock_op;
  logic [GW-1:0] rd_grp;
  logic [DATA_W-1:0] rd_word;
  logic [7:0] byte_out;
  logic cs_rise;

  // ==========================================================================
  // Reset release
  // Latch and lock instructions are dropped until the synchronised reset copy releases; reads are still served.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ==========================================================================
  // Link: frame decoder on the serial clock
  // Chip select high clears the frame state asynchronously, so a read ends
  // the instant the master deselects, whatever bit it was on.
  assign byte_in = {link_ff.sr[6:0], si};
  assign addr_inc = link_ff.addr[5] ? link_ff.addr : link_ff.addr + 6'h01;
  assign is_read_op = (link_ff.cmd & OP_X_MASK) == OP_ID_READ;
  assign is_lock_op = (link_ff.cmd & OP_X_MASK) == OP_ID_WRITE;

  always_comb begin
    nxt_link = link_ff;
    nxt_link.sr = byte_in;
    nxt_link.bitpos = link_ff.bitpos + 3'h1;
    nxt_link.load = 1'b0;
    if (link_ff.bitpos == 3'h7) begin
      if (link_ff.byte_idx != 2'h3) begin
        nxt_link.byte_idx = link_ff.byte_idx + 2'h1;
      end
      if (link_ff.byte_idx == 2'h0) begin
        nxt_link.cmd = byte_in;
      end
      if (link_ff.byte_idx == 2'h2) begin
        nxt_link.a7 = byte_in[ADDR_SEL_BIT];
        if (is_read_op && !keep_ff.busy_s2) begin
          nxt_link.rd_ls = byte_in[ADDR_SEL_BIT];
          nxt_link.rd_id = !byte_in[ADDR_SEL_BIT];
          nxt_link.addr = {1'b0, byte_in[4:0]};
          nxt_link.load = 1'b1;
        end
      end
      if (link_ff.byte_idx == 2'h3 && (link_ff.rd_id || link_ff.rd_ls)) begin
        if (link_ff.rd_id) begin
          nxt_link.addr = addr_inc;
        end
        nxt_link.load = 1'b1;
      end
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      link_ff <= '0;
    end else begin
      link_ff <= nxt_link;
    end
  end

  // ==========================================================================
  // Link: events and status that outlive the frame
  // The event is rewritten on every rising serial edge, so a stray clock after the
  // boundary byte withdraws it before chip select can commit it.
  always_comb begin
    nxt_keep = keep_ff;
    nxt_keep.busy_s1 = core_ff.state != ST_IDLE;
    nxt_keep.busy_s2 = keep_ff.busy_s1;
    nxt_keep.lock_s1 = core_ff.locked;
    nxt_keep.lock_s2 = keep_ff.lock_s1;
    nxt_keep.evt = EV_NONE;
    if (link_ff.bitpos == 3'h7) begin
      if (link_ff.byte_idx == 2'h0 && (byte_in & OP_X_MASK) == SET_LATCH_CODE) begin
        nxt_keep.evt = EV_SET_LATCH;
      end
      if (link_ff.byte_idx == 2'h3 && is_lock_op && link_ff.a7 &&
          byte_in[LOCK_DATA_BIT]) begin
        nxt_keep.evt = EV_LOCK;
      end
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      keep_ff <= '0;
    end else begin
      keep_ff <= nxt_keep;
    end
  end

  // ==========================================================================
  // Page storage
  // The read port fetches the group of the byte due next, so the word is
  // ready on the falling edge that loads it.
  assign rd_grp = (link_ff.byte_idx == 2'h3) ? addr_inc[4:2] : link_ff.sr[3:1];

  seidp_idmem #(
    .NGROUPS(GROUPS)
  ) u_idmem (
    .wclk(clk),
    .we(core_ff.mem_we),
    .waddr(core_ff.mem_addr),
    .wdata(core_ff.mem_data),
    .rclk(sck),
    .rgrp(rd_grp),
    .rdata(rd_word)
  );

  // ==========================================================================
  // Link: output shifter on the falling serial edge
  always_comb begin
    if (link_ff.rd_ls) begin
      byte_out = {7'h00, keep_ff.lock_s2};
    end else if (link_ff.addr[5]) begin
      byte_out = ERASED_BYTE;
    end else begin
      byte_out = rd_word[{link_ff.addr[1:0], 3'b000} +: 8];
    end
  end

  always_comb begin
    nxt_out = out_ff;
    if (link_ff.load) begin
      nxt_out.so_sh = byte_out;
    end else begin
      nxt_out.so_sh = {out_ff.so_sh[6:0], 1'b1};
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_ff <= '1;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign so_out = out_ff.so_sh[7];
  assign so_oe = link_ff.rd_id | link_ff.rd_ls;

  // ==========================================================================
  // Core: commit at deselect, self-timed write cycles
  // Chip select and the event both cross through two flops; the event is
  // settled before chip select rises, so at the synchronised rise it is
  // stable. The master must keep chip select high for at least four core
  // clocks so the next frame cannot overwrite the event first.
  assign cs_rise = core_ff.cs_s2 && !core_ff.cs_prev;

  always_comb begin
    nxt_core = core_ff;
    nxt_core.cs_s1 = cs_n;
    nxt_core.cs_s2 = core_ff.cs_s1;
    nxt_core.cs_prev = core_ff.cs_s2;
    nxt_core.evt_s1 = keep_ff.evt;
    nxt_core.evt_s2 = core_ff.evt_s1;
    nxt_core.mem_we = 1'b0;
    nxt_core.ack = 1'b0;
    unique case (core_ff.state)
      ST_IDLE: begin
        if (cs_rise && core_ff.evt_s2 == EV_SET_LATCH) begin
          nxt_core.wr_latch = 1'b1;
        end else if (cs_rise && core_ff.evt_s2 == EV_LOCK) begin
          if (core_ff.wr_latch &&
              !(protect_sel_high && protect_sel_low) &&
              !core_ff.locked) begin
            nxt_core.state = ST_LOCK;
            nxt_core.timer = TW'(WR_CYCLES_P - 1);
          end
        end else if (wr_req && !core_ff.locked) begin
          nxt_core.mem_we = 1'b1;
          nxt_core.mem_addr = wr_addr;
          nxt_core.mem_data = wr_data;
          nxt_core.ack = 1'b1;
          nxt_core.state = ST_WRITE;
          nxt_core.timer = TW'(WR_CYCLES_P - 1);
        end
      end
      ST_LOCK, ST_WRITE: begin
        // Lock attempts and latch settings that arrive now are dropped.
        if (core_ff.timer == '0) begin
          nxt_core.state = ST_IDLE;
          if (core_ff.state == ST_LOCK) begin
            nxt_core.locked = 1'b1;
            nxt_core.wr_latch = 1'b0;
          end
        end else begin
          nxt_core.timer = core_ff.timer - TW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ff <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, evt_s1: EV_NONE,
                   evt_s2: EV_NONE, wr_latch: 1'b0, state: ST_IDLE, timer: '0,
                   locked: 1'b0, mem_we: 1'b0, mem_addr: 5'h00, mem_data: 8'h00,
                   ack: 1'b0};
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign wr_ack = core_ff.ack;
  assign write_latch_bit = core_ff.wr_latch;
  assign busy = core_ff.state != ST_IDLE;
  assign page_locked = core_ff.locked;

endmodule // seidp_top

/* File: tb/seidp_host.sv */
`timescale 1ns/1ps
module seidp_host
  import seidp_pkg::*;
(
  // Link pins driven by the host
  output logic sck,
  output logic cs_n,
  output logic si,
  // Link pins driven by the device
  input wire logic so_out,
  input wire logic so_oe
);
  // ==========================================================================
  // Frame engine
  logic [7:0] rx [4];
  logic oe_seen;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // The clock stands low between frames; idle data toggles so a stale level is never trusted.
  task automatic xfer(input logic [47:0] w, input int nbits, input int nrd);
    #7;
    cs_n = 1'b0;
    oe_seen = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = w[47-i];
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
    for (int b = 0; b < nrd; b++) begin
      for (int i = 7; i >= 0; i--) begin
        si = ~si;
        #16 sck = 1'b1;
        rx[b][i] = so_out;
        oe_seen = oe_seen | so_oe;
        #16 sck = 1'b0;
      end
    end
    #8 cs_n = 1'b1;
    si = ~si;
    #100;
  endtask
endmodule // seidp_host

/* File: tb/seidp_chk.sv */
`timescale 1ns/1ps
module seidp_chk
  import seidp_pkg::*;
#(
  parameter int WR_CYCLES_P = 20
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic cs_n,
  input wire logic so_oe,
  // Protect selection
  input wire logic protect_sel_high,
  input wire logic protect_sel_low,
  // Page load and status
  input wire logic wr_req,
  input wire logic wr_ack,
  input wire logic write_latch_bit,
  input wire logic busy,
  input wire logic page_locked
);
  // ==========================================================================
  // Busy length counter
  int busy_cnt_ff;
  int nxt_busy_cnt;

  always_comb begin
    nxt_busy_cnt = busy ? busy_cnt_ff + 1 : 0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_lock_needs_latch: assert property ($rose(busy) && !wr_ack |-> write_latch_bit)
    else $error("lock cycle started without write latch");
  chk_lock_protect_ok: assert property ($rose(busy) && !wr_ack |->
    !(protect_sel_high && protect_sel_low))
    else $error("lock cycle started with both protect bits set");
  chk_lock_not_twice: assert property ($rose(busy) && !wr_ack |-> !page_locked)
    else $error("lock cycle started on a locked page");
  chk_busy_length: assert property ($fell(busy) |-> busy_cnt_ff == WR_CYCLES_P)
    else $error("write cycle length wrong");
  chk_lock_end_state: assert property ($rose(page_locked) |-> $fell(busy) && !write_latch_bit)
    else $error("lock end did not clear latch with busy");
  chk_lock_sticks: assert property (page_locked |=> page_locked)
    else $error("lock state dropped");
  chk_locked_no_load: assert property (page_locked && wr_req |=> !wr_ack)
    else $error("load accepted on locked page");
  chk_load_accept: assert property (wr_req && !busy && !page_locked |=> wr_ack && busy)
    else $error("load not accepted");
  chk_ack_pulse: assert property (wr_ack |-> busy ##1 (!wr_ack && busy))
    else $error("load ack not a single pulse");
  chk_deselect_quiet: assert property (cs_n |-> !so_oe)
    else $error("output driven while deselected");
  chk_read_blocked: assert property ($rose(so_oe) |-> !busy)
    else $error("read accepted during write cycle");
endmodule // seidp_chk

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import seidp_pkg::*;
  // Short write cycle keeps the run brief; still long enough to read during it.
  localparam int WRC = 150;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sck, cs_n, si, so_out, so_oe, wr_ack, write_latch_bit, busy, page_locked;
  logic protect_sel_high = 1'b0;
  logic protect_sel_low = 1'b0;
  logic wr_req = 1'b0;
  logic [4:0] wr_addr = 5'h00;
  logic [7:0] wr_data = 8'h00;
  int fail_count = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  seidp_top #(.WR_CYCLES_P(WRC)) i_seidp_top (.clk(clk), .resetn(resetn), .sck(sck),
    .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe), .protect_sel_high(protect_sel_high),
    .protect_sel_low(protect_sel_low), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ack(wr_ack), .write_latch_bit(write_latch_bit), .busy(busy), .page_locked(page_locked));
  seidp_host i_seidp_host (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));

  // ==========================================================================
  // Common tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic settle();
    int n = 0;
    repeat (6) @(negedge clk);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      fail_count++;
      $display("MISMATCH busy wait expected 0 seen 1");
      complete_run();
    end
  endtask

  task automatic load(input logic [4:0] a, input logic [7:0] d, input logic ack);
    @(negedge clk);
    wr_req = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_req = 1'b0;
    check("wr_ack", {7'h00, wr_ack}, {7'h00, ack});
    settle();
  endtask

  task automatic set_latch();
    i_seidp_host.xfer(48'h0600_0000_0000, 8, 0);
    @(negedge clk);
  endtask

  task automatic lock_try(input int nbits);
    i_seidp_host.xfer(48'h8200_8002_0200, nbits, 0);
    @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_erased();
    i_seidp_host.xfer(48'h8300_1E00_0000, 24, 2);
    check("id byte 30", i_seidp_host.rx[0], 8'hFF);
    check("id byte 31", i_seidp_host.rx[1], 8'hFF);
    $display("test erased done");
  endtask

  task automatic t_load();
    logic [7:0] exp [4] = '{8'hFF, 8'h5A, 8'hA5, 8'hFF};
    load(5'h05, 8'h5A, 1'b1);
    load(5'h06, 8'hA5, 1'b1);
    // One stored bit of byte 5 goes bad; the read must still return the loaded value.
    i_seidp_top.u_idmem.mem[1][8] = ~i_seidp_top.u_idmem.mem[1][8];
    i_seidp_host.xfer(48'h83FF_6400_0000, 24, 4);
    for (int i = 0; i < 4; i++) begin
      check("group byte", i_seidp_host.rx[i], exp[i]);
    end
    $display("test load done");
  endtask

  task automatic t_status(input logic lk);
    i_seidp_host.xfer(48'h837F_FF00_0000, 24, 2);
    check("lock state", i_seidp_host.rx[0], {7'h00, lk});
    check("lock state again", i_seidp_host.rx[1], {7'h00, lk});
    $display("test status done");
  endtask

  task automatic t_refuse();
    lock_try(40);
    check("busy without latch", {7'h00, busy}, 8'h00);
    set_latch();
    check("latch", {7'h00, write_latch_bit}, 8'h01);
    protect_sel_high = 1'b1;
    protect_sel_low = 1'b1;
    lock_try(40);
    check("busy protected", {7'h00, busy}, 8'h00);
    protect_sel_low = 1'b0;
    lock_try(41);
    check("busy extra clock", {7'h00, busy}, 8'h00);
    lock_try(36);
    check("busy mid byte", {7'h00, busy}, 8'h00);
    @(negedge clk);
    wr_req = 1'b1;
    wr_addr = 5'h10;
    wr_data = 8'h3C;
    @(negedge clk);
    wr_req = 1'b0;
    lock_try(40);
    settle();
    check("lock during write", {7'h00, page_locked}, 8'h00);
    $display("test refuse done");
  endtask

  task automatic t_lock();
    lock_try(40);
    check("busy lock", {7'h00, busy}, 8'h01);
    i_seidp_host.xfer(48'h8300_0500_0000, 24, 1);
    check("read while busy", {7'h00, i_seidp_host.oe_seen}, 8'h00);
    i_seidp_host.xfer(48'h8300_8000_0000, 24, 1);
    check("state while busy", {7'h00, i_seidp_host.oe_seen}, 8'h00);
    settle();
    check("locked", {7'h00, page_locked}, 8'h01);
    check("latch cleared", {7'h00, write_latch_bit}, 8'h00);
    $display("test lock done");
  endtask

  task automatic t_frozen();
    load(5'h05, 8'h00, 1'b0);
    i_seidp_host.xfer(48'h8300_0500_0000, 24, 1);
    check("kept byte", i_seidp_host.rx[0], 8'h5A);
    set_latch();
    lock_try(40);
    check("busy relock", {7'h00, busy}, 8'h00);
    t_status(1'b1);
    $display("test frozen done");
  endtask

  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    t_erased();
    t_load();
    t_status(1'b0);
    t_refuse();
    t_lock();
    t_frozen();
    complete_run();
  end
endmodule // testbench

bind seidp_top seidp_chk #(.WR_CYCLES_P(WR_CYCLES_P)) i_seidp_chk (.clk(clk), .resetn(resetn),
  .cs_n(cs_n), .so_oe(so_oe), .protect_sel_high(protect_sel_high),
  .protect_sel_low(protect_sel_low), .wr_req(wr_req), .wr_ack(wr_ack),
  .write_latch_bit(write_latch_bit), .busy(busy), .page_locked(page_locked));
